// ==== hdl/pdr_gpio_top.sv ====
// pin output data and pad pull enable registers with pad control, wishbone slave
// How it works
// - drive stored data only for GPIO-mode outputs
// - data registers at 0x08 low, 0x0C high
// - data resets zero, pins 22-25 reset one
// - pull enable governs pull for input pads
// - pull select picks up or down
// - pull enable bit 1 enables; resets all ones
// - pull forced off while pad is output
// - pull enables at 0x10 low, 0x14 high
// - direction 0 input, 1 output in GPIO mode
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "pdr_defines.svh"
module pdr_gpio_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // settings held elsewhere in the unit
    input wire logic [63:0] pad_dir_i,
    input wire logic [127:0] func_sel_i,
    input wire logic [63:0] pull_sel_i,
    // alternate function pad control
    input wire logic [63:0] alt_oe_i,
    input wire logic [63:0] alt_do_i,
    // pads
    output logic [63:0] pad_do_o,
    output logic [63:0] pad_oe_n_o,
    output logic [63:0] pull_en_o,
    output logic [63:0] pull_up_o
);
    pdr_pkg::pdr_regs_t r;
    pdr_pkg::pdr_regs_t next_r;
    pdr_pkg::pdr_reg_t wr_reg;
    pdr_pkg::pdr_reg_t rd_reg;
    logic [63:0] data_vec;
    logic [63:0] pu_vec;
    logic [63:0] drv_vec;

    pdr_reg_if u_bus ();

    // address decode shared by the write and read paths
    function automatic pdr_pkg::pdr_reg_t decode(input logic [7:0] adr);
        logic [7:0] a;
        a = {adr[7:2], 2'h0};
        if (a == `PDR_OFS_DATA_LO) begin
            decode = pdr_pkg::reg_data_lo;
        end else if (a == `PDR_OFS_DATA_HI) begin
            decode = pdr_pkg::reg_data_hi;
        end else if (a == `PDR_OFS_PU_LO) begin
            decode = pdr_pkg::reg_pu_lo;
        end else if (a == `PDR_OFS_PU_HI) begin
            decode = pdr_pkg::reg_pu_hi;
        end else if (a == `PDR_OFS_DRV_LO) begin
            decode = pdr_pkg::reg_drv_lo;
        end else if (a == `PDR_OFS_DRV_HI) begin
            decode = pdr_pkg::reg_drv_hi;
        end else begin
            decode = pdr_pkg::reg_none;
        end
    endfunction

    // byte lanes honoured; full-word writes are the intended use
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] sel
    );
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                m[8*b +: 8] = wd[8*b +: 8];
            end
        end
        merge = m;
    endfunction

    pdr_wb_slave u_wb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .bus(u_bus.bus)
    );

    assign wr_reg = decode(u_bus.addr);
    assign rd_reg = decode(u_bus.addr);

    always_comb begin
        next_r = r;
        if (u_bus.wr) begin
            case (wr_reg)
                pdr_pkg::reg_data_lo: begin
                    next_r.data_lo = merge(r.data_lo, u_bus.wdata, u_bus.sel);
                end
                pdr_pkg::reg_data_hi: begin
                    next_r.data_hi = merge(r.data_hi, u_bus.wdata, u_bus.sel);
                end
                pdr_pkg::reg_pu_lo: begin
                    next_r.pu_lo = merge(r.pu_lo, u_bus.wdata, u_bus.sel);
                end
                pdr_pkg::reg_pu_hi: begin
                    next_r.pu_hi = merge(r.pu_hi, u_bus.wdata, u_bus.sel);
                end
                default: begin
                    // status and unmapped words ignore writes
                    next_r = r;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r.data_lo <= `PDR_DATA_LO_RST;
            r.data_hi <= `PDR_DATA_HI_RST;
            r.pu_lo <= `PDR_PU_RST;
            r.pu_hi <= `PDR_PU_RST;
        end else begin
            r <= next_r;
        end
    end

    // status shows pins really driven, after mode and direction
    always_comb begin
        case (rd_reg)
            pdr_pkg::reg_data_lo: begin
                u_bus.rdata = r.data_lo;
            end
            pdr_pkg::reg_data_hi: begin
                u_bus.rdata = r.data_hi;
            end
            pdr_pkg::reg_pu_lo: begin
                u_bus.rdata = r.pu_lo;
            end
            pdr_pkg::reg_pu_hi: begin
                u_bus.rdata = r.pu_hi;
            end
            pdr_pkg::reg_drv_lo: begin
                u_bus.rdata = ~pad_oe_n_o[31:0];
            end
            pdr_pkg::reg_drv_hi: begin
                u_bus.rdata = ~pad_oe_n_o[63:32];
            end
            default: begin
                u_bus.rdata = 32'h00000000;
            end
        endcase
    end

    assign data_vec = {r.data_hi, r.data_lo};
    assign pu_vec = {r.pu_hi, r.pu_lo};

    pdr_pad_ctrl u_pad (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .data_i(data_vec),
        .pu_en_i(pu_vec),
        .dir_i(pad_dir_i),
        .func_i(func_sel_i),
        .pull_sel_i(pull_sel_i),
        .alt_oe_i(alt_oe_i),
        .alt_do_i(alt_do_i),
        .pad_do_o(pad_do_o),
        .pad_oe_n_o(pad_oe_n_o),
        .pull_en_o(pull_en_o),
        .pull_up_o(pull_up_o)
    );

    // helper vectors read only by the checks below
    logic [63:0] gpio_mode_vec;
    logic [63:0] gpio_in_vec;
    logic take;

    for (genvar i = 0; i < `PDR_NPINS; i++) begin : g_chk
        assign gpio_mode_vec[i] = func_sel_i[`PDR_FUNC_W*i +: `PDR_FUNC_W] == `PDR_FUNC_GPIO;
    end
    assign drv_vec = gpio_mode_vec & pad_dir_i;
    assign gpio_in_vec = gpio_mode_vec & ~pad_dir_i;
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    property p_data_lo_wr;
        @(posedge clk_i) disable iff (rst_i)
        (take && wb_we_i && wb_sel_i == 4'hF && {wb_adr_i[7:2], 2'h0} == `PDR_OFS_DATA_LO)
        |=> (r.data_lo == $past(wb_dat_i)) && wb_ack_o;
    endproperty
    a_data_lo_wr: assert property (p_data_lo_wr)
        else $error("low data word not written");

    property p_data_hi_wr;
        @(posedge clk_i) disable iff (rst_i)
        (take && wb_we_i && wb_sel_i == 4'hF && {wb_adr_i[7:2], 2'h0} == `PDR_OFS_DATA_HI)
        |=> (r.data_hi == $past(wb_dat_i)) && $stable(r.data_lo);
    endproperty
    a_data_hi_wr: assert property (p_data_hi_wr)
        else $error("high data word not written");

    property p_data_rst;
        @(posedge clk_i)
        rst_i |=> (r.data_lo == `PDR_DATA_LO_RST) && (r.data_hi == `PDR_DATA_HI_RST);
    endproperty
    a_data_rst: assert property (p_data_rst)
        else $error("data reset value wrong");

    property p_pu_rst;
        @(posedge clk_i)
        rst_i |=> (r.pu_lo == `PDR_PU_RST) && (r.pu_hi == `PDR_PU_RST);
    endproperty
    a_pu_rst: assert property (p_pu_rst)
        else $error("pull enable reset value wrong");

    property p_pu_wr;
        @(posedge clk_i) disable iff (rst_i)
        (take && wb_we_i && wb_sel_i == 4'hF && {wb_adr_i[7:2], 2'h0} == `PDR_OFS_PU_HI)
        |=> (r.pu_hi == $past(wb_dat_i)) && $stable(r.pu_lo);
    endproperty
    a_pu_wr: assert property (p_pu_wr)
        else $error("high pull enable word not written");

    property p_gpio_drive;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (((pad_do_o ^ $past(data_vec)) & $past(drv_vec)) == 64'h0)
            && ((pad_oe_n_o & $past(drv_vec)) == 64'h0);
    endproperty
    a_gpio_drive: assert property (p_gpio_drive)
        else $error("gpio output pin not driving stored data");

    property p_gpio_input;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ((~pad_oe_n_o & $past(gpio_in_vec)) == 64'h0);
    endproperty
    a_gpio_input: assert property (p_gpio_input)
        else $error("gpio input pin is driven");

    property p_pull_in;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (((pull_en_o ^ $past(pu_vec)) & pad_oe_n_o) == 64'h0);
    endproperty
    a_pull_in: assert property (p_pull_in)
        else $error("input pull does not follow enable bit");

    // held against the inputs, so a wrong output enable cannot hide a live pull
    property p_pull_out;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ((pull_en_o & ($past(drv_vec) | ($past(alt_oe_i) & ~$past(gpio_mode_vec))))
            == 64'h0);
    endproperty
    a_pull_out: assert property (p_pull_out)
        else $error("pull left on for output pin");

    property p_pull_dir;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (pull_up_o == $past(pull_sel_i));
    endproperty
    a_pull_dir: assert property (p_pull_dir)
        else $error("pull direction does not follow select");

    property p_read_back;
        @(posedge clk_i) disable iff (rst_i)
        (take && !wb_we_i && {wb_adr_i[7:2], 2'h0} == `PDR_OFS_DATA_LO)
        |=> wb_ack_o && (wb_dat_o == $past(r.data_lo));
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("low data read back wrong");

    property p_unmapped;
        @(posedge clk_i) disable iff (rst_i)
        (take && !wb_we_i && decode(wb_adr_i) == pdr_pkg::reg_none)
        |=> wb_ack_o && (wb_dat_o == 32'h00000000) ##1 !wb_ack_o;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_pu_lo_wr;
        @(posedge clk_i) disable iff (rst_i)
        (take && wb_we_i && wb_sel_i == 4'hF && {wb_adr_i[7:2], 2'h0} == `PDR_OFS_PU_LO)
        |=> (r.pu_lo == $past(wb_dat_i)) && $stable(r.pu_hi);
    endproperty
    a_pu_lo_wr: assert property (p_pu_lo_wr)
        else $error("low pull enable word not written");

    property p_pu_read;
        @(posedge clk_i) disable iff (rst_i)
        (take && !wb_we_i && {wb_adr_i[7:2], 2'h0} == `PDR_OFS_PU_HI)
        |=> wb_ack_o && (wb_dat_o == $past(r.pu_hi));
    endproperty
    a_pu_read: assert property (p_pu_read)
        else $error("high pull enable read back wrong");

    property p_drv_status;
        @(posedge clk_i) disable iff (rst_i)
        (take && !wb_we_i && {wb_adr_i[7:2], 2'h0} == `PDR_OFS_DRV_LO)
        |=> wb_ack_o && (wb_dat_o == ~$past(pad_oe_n_o[31:0]));
    endproperty
    a_drv_status: assert property (p_drv_status)
        else $error("drive status word wrong");

    // unmapped words and the low status word must never disturb the stored registers
    property p_status_ro;
        @(posedge clk_i) disable iff (rst_i)
        (take && wb_we_i && (decode(wb_adr_i) == pdr_pkg::reg_none
            || decode(wb_adr_i) == pdr_pkg::reg_drv_lo)) |=> $stable(r);
    endproperty
    a_status_ro: assert property (p_status_ro)
        else $error("write to read-only word changed a register");

    property p_pad_rst;
        @(posedge clk_i)
        rst_i |=> (pad_oe_n_o == 64'hFFFFFFFFFFFFFFFF)
            && (pull_en_o == 64'hFFFFFFFFFFFFFFFF);
    endproperty
    a_pad_rst: assert property (p_pad_rst)
        else $error("pad reset state wrong");

    property p_lane_write;
        @(posedge clk_i) disable iff (rst_i)
        (take && wb_we_i && wb_sel_i == 4'h1 && {wb_adr_i[7:2], 2'h0} == `PDR_OFS_DATA_HI)
        |=> (r.data_hi == {$past(r.data_hi[31:8]), $past(wb_dat_i[7:0])});
    endproperty
    a_lane_write: assert property (p_lane_write)
        else $error("byte lane write not merged");

    property p_alt_drive;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (((pad_do_o ^ $past(alt_do_i)) & ~$past(gpio_mode_vec)) == 64'h0)
            && (((pad_oe_n_o ^ ~$past(alt_oe_i)) & ~$past(gpio_mode_vec)) == 64'h0);
    endproperty
    a_alt_drive: assert property (p_alt_drive)
        else $error("alternate function pad not following its inputs");
endmodule // pdr_gpio_top

// ==== pkg/pdr_defines.svh ====
// offsets, reset values and field constants of the pin data / pull enable registers
`ifndef PDR_DEFINES_SVH
`define PDR_DEFINES_SVH

`define PDR_ADR_W 8
`define PDR_OFS_DATA_LO 8'h08
`define PDR_OFS_DATA_HI 8'h0C
`define PDR_OFS_PU_LO 8'h10
`define PDR_OFS_PU_HI 8'h14
`define PDR_OFS_DRV_LO 8'h68
`define PDR_OFS_DRV_HI 8'h6C
`define PDR_DATA_LO_RST 32'h03C00000
`define PDR_DATA_HI_RST 32'h00000000
`define PDR_PU_RST 32'hFFFFFFFF
`define PDR_NPINS 64
`define PDR_FUNC_W 2
`define PDR_FUNC_GPIO 2'h0

`endif

// ==== pkg/pdr_pkg.sv ====
// types shared by the pin data / pull enable register block
package pdr_pkg;
    typedef enum logic [2:0] {
        reg_none = 3'b000,
        reg_data_lo = 3'b001,
        reg_data_hi = 3'b010,
        reg_pu_lo = 3'b011,
        reg_pu_hi = 3'b100,
        reg_drv_lo = 3'b101,
        reg_drv_hi = 3'b110
    } pdr_reg_t;
    typedef struct packed {
        logic [31:0] data_lo;
        logic [31:0] data_hi;
        logic [31:0] pu_lo;
        logic [31:0] pu_hi;
    } pdr_regs_t;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } pdr_wb_st_t;
    typedef struct packed {
        logic [63:0] pad_do;
        logic [63:0] pad_oe_n;
        logic [63:0] pull_en;
        logic [63:0] pull_up;
    } pdr_pad_st_t;
endpackage

// ==== pkg/pdr_reg_if.sv ====
// register access strobes between the bus slave and the register file
`timescale 1ns/1ps
interface pdr_reg_if;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] sel;
    logic [31:0] rdata;
    modport bus (output wr, output addr, output wdata, output sel, input rdata);
    modport regs (input wr, input addr, input wdata, input sel, output rdata);
endinterface

// ==== hdl/pdr_wb_slave.sv ====
// classic wishbone slave: one-cycle access strobe, registered ack and read data
`timescale 1ns/1ps
module pdr_wb_slave (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // register side
    pdr_reg_if.bus bus
);
    pdr_pkg::pdr_wb_st_t st;
    pdr_pkg::pdr_wb_st_t next_st;
    logic take;

    // ack blocks a second take while the master still holds the request
    assign take = wb_cyc_i & wb_stb_i & ~st.ack;
    assign bus.wr = take & wb_we_i;
    assign bus.addr = wb_adr_i;
    assign bus.wdata = wb_dat_i;
    assign bus.sel = wb_sel_i;

    always_comb begin
        next_st = st;
        next_st.ack = take;
        if (take) begin
            next_st.dat = wb_we_i ? 32'h00000000 : bus.rdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.dat;

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single cycle pulse");
endmodule // pdr_wb_slave

// ==== hdl/pdr_pad_ctrl.sv ====
// per-pin pad drive, output enable and pull control, all registered
`timescale 1ns/1ps
`include "pdr_defines.svh"
module pdr_pad_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // settings
    input wire logic [63:0] data_i,
    input wire logic [63:0] pu_en_i,
    input wire logic [63:0] dir_i,
    input wire logic [127:0] func_i,
    input wire logic [63:0] pull_sel_i,
    input wire logic [63:0] alt_oe_i,
    input wire logic [63:0] alt_do_i,
    // pads
    output logic [63:0] pad_do_o,
    output logic [63:0] pad_oe_n_o,
    output logic [63:0] pull_en_o,
    output logic [63:0] pull_up_o
);
    pdr_pkg::pdr_pad_st_t st;
    pdr_pkg::pdr_pad_st_t next_st;
    logic [63:0] nxt_do;
    logic [63:0] nxt_out;

    for (genvar i = 0; i < `PDR_NPINS; i++) begin : g_pin
        logic gpio_mode;
        assign gpio_mode = func_i[`PDR_FUNC_W*i +: `PDR_FUNC_W] == `PDR_FUNC_GPIO;
        // in alternate modes the peripheral owns direction and data
        assign nxt_out[i] = gpio_mode ? dir_i[i] : alt_oe_i[i];
        assign nxt_do[i] = gpio_mode ? data_i[i] : alt_do_i[i];
    end

    always_comb begin
        next_st.pad_do = nxt_do;
        next_st.pad_oe_n = ~nxt_out;
        next_st.pull_en = pu_en_i & ~nxt_out;
        next_st.pull_up = pull_sel_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.pad_do <= '0;
            st.pad_oe_n <= '1;
            st.pull_en <= {`PDR_PU_RST, `PDR_PU_RST};
            st.pull_up <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pad_do_o = st.pad_do;
    assign pad_oe_n_o = st.pad_oe_n;
    assign pull_en_o = st.pull_en;
    assign pull_up_o = st.pull_up;
endmodule // pdr_pad_ctrl

// ==== testbench/pdr_gpio_top_tb.sv ====
// self-checking bench for the pin data and pull enable register block
`timescale 1ns/1ps
`include "pdr_defines.svh"
`define TB_CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end
module pdr_gpio_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [63:0] pad_dir_i = 64'h0;
    logic [127:0] func_sel_i = 128'h0;
    logic [63:0] pull_sel_i = 64'h0;
    logic [63:0] alt_oe_i = 64'h0;
    logic [63:0] alt_do_i = 64'h0;
    logic [63:0] pad_do_o;
    logic [63:0] pad_oe_n_o;
    logic [63:0] pull_en_o;
    logic [63:0] pull_up_o;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] rd;

    pdr_gpio_top i_pdr_gpio_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_dir_i(pad_dir_i),
        .func_sel_i(func_sel_i), .pull_sel_i(pull_sel_i), .alt_oe_i(alt_oe_i),
        .alt_do_i(alt_do_i), .pad_do_o(pad_do_o), .pad_oe_n_o(pad_oe_n_o),
        .pull_en_o(pull_en_o), .pull_up_o(pull_up_o)
    );

    always #12.5 clk_i = ~clk_i;

    task automatic results();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // a hang ends the run through the same report
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            results();
        end
    end

    // one classic cycle; caller stands just after a rising edge
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                           input logic [31:0] wd, output logic [31:0] rdat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wd;
        // only the bench timeout ends a wait for ack
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        // idle cycle keeps cyc low before the next request
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] dummy;
        wb_xfer(1'b1, adr, 4'hF, wd, dummy);
    endtask

    task automatic rdw(input logic [7:0] adr, output logic [31:0] rdat);
        wb_xfer(1'b0, adr, 4'hF, 32'h00000000, rdat);
    endtask

    task automatic apply_reset();
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // pads follow a setting change within two edges
    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask

    task automatic t_reset_values();
        pad_dir_i <= 64'h0;
        func_sel_i <= 128'h0;
        settle();
        `TB_CHK(pull_en_o, 64'hFFFFFFFFFFFFFFFF)
        `TB_CHK(pad_oe_n_o, 64'hFFFFFFFFFFFFFFFF)
        rdw(`PDR_OFS_DATA_LO, rd);
        `TB_CHK(rd, 32'h03C00000)
        rdw(`PDR_OFS_DATA_HI, rd);
        `TB_CHK(rd, 32'h00000000)
        rdw(`PDR_OFS_PU_LO, rd);
        `TB_CHK(rd, 32'hFFFFFFFF)
        rdw(`PDR_OFS_PU_HI, rd);
        `TB_CHK(rd, 32'hFFFFFFFF)
    endtask

    task automatic t_regs_rw();
        wr(`PDR_OFS_DATA_LO, 32'hA5A50F0F);
        wr(`PDR_OFS_DATA_HI, 32'h12345678);
        wr(`PDR_OFS_PU_LO, 32'h0000FFFF);
        wr(`PDR_OFS_PU_HI, 32'hC3C3C3C3);
        // unmapped place: write dropped, reads zero
        wr(8'h40, 32'hDEADBEEF);
        rdw(8'h40, rd);
        `TB_CHK(rd, 32'h00000000)
        rdw(`PDR_OFS_DATA_LO, rd);
        `TB_CHK(rd, 32'hA5A50F0F)
        rdw(`PDR_OFS_DATA_HI, rd);
        `TB_CHK(rd, 32'h12345678)
        rdw(`PDR_OFS_PU_LO, rd);
        `TB_CHK(rd, 32'h0000FFFF)
        rdw(`PDR_OFS_PU_HI, rd);
        `TB_CHK(rd, 32'hC3C3C3C3)
    endtask

    task automatic t_lane_write();
        wb_xfer(1'b1, `PDR_OFS_DATA_HI, 4'h1, 32'hAABBCCDD, rd);
        rdw(`PDR_OFS_DATA_HI, rd);
        `TB_CHK(rd, 32'h123456DD)
        wr(`PDR_OFS_DATA_HI, 32'h12345678);
    endtask

    task automatic t_gpio_pads();
        logic [63:0] dir;
        dir = 64'h00FF00FFF0F00F0F;
        pad_dir_i <= dir;
        func_sel_i <= 128'h0;
        pull_sel_i <= 64'h0123456789ABCDEF;
        settle();
        `TB_CHK(pad_do_o & dir, 64'h12345678A5A50F0F & dir)
        `TB_CHK(pad_oe_n_o, ~dir)
        `TB_CHK(pull_en_o, 64'hC3C3C3C30000FFFF & ~dir)
        `TB_CHK(pull_up_o, 64'h0123456789ABCDEF)
        pad_dir_i <= 64'h0;
        pull_sel_i <= 64'hFEDCBA9876543210;
        settle();
        `TB_CHK(pull_en_o, 64'hC3C3C3C30000FFFF)
        `TB_CHK(pull_up_o, 64'hFEDCBA9876543210)
    endtask

    // low pins on alternate functions, high pins in GPIO mode as outputs
    task automatic t_alt_pads();
        pad_dir_i <= 64'hFFFFFFFFFFFFFFFF;
        func_sel_i <= {64'h0, {16{4'b1001}}};
        alt_oe_i <= 64'h000000003333CCCC;
        alt_do_i <= 64'hFFFFFFFF5A5A5A5A;
        settle();
        `TB_CHK(pad_oe_n_o, {32'h00000000, ~32'h3333CCCC})
        `TB_CHK(pad_do_o, 64'h123456785A5A5A5A)
        `TB_CHK(pull_en_o, {32'h00000000, 32'h0000FFFF & ~32'h3333CCCC})
        // status words are read-only and show the pins really driven
        wr(`PDR_OFS_DRV_LO, 32'h00000000);
        rdw(`PDR_OFS_DRV_LO, rd);
        `TB_CHK(rd, 32'h3333CCCC)
        rdw(`PDR_OFS_DRV_HI, rd);
        `TB_CHK(rd, 32'hFFFFFFFF)
        alt_oe_i <= 64'h0;
        settle();
        `TB_CHK(pull_en_o, 64'h000000000000FFFF)
    endtask

    initial begin
        apply_reset();
        t_reset_values();
        t_regs_rw();
        t_lane_write();
        t_gpio_pads();
        t_alt_pads();
        // a second reset in mid-run restores every reset value
        apply_reset();
        alt_oe_i <= 64'h0;
        t_reset_values();
        results();
    end
endmodule // pdr_gpio_top_tb
